// >>> core/urs_reg_bank.sv
// UART reset-state register bank with AXI4-Lite slave and reset-level outputs
// Operation
// - Four read/write pause and resume characters; no flow control logic reads them.
// - Reset clears control registers; status 0x01, line status 0x60, scratch 0xFF.
// - Reset clears the four modem status change bits.
// - Upper modem status bits follow modem input pin levels after reset.
// - Transmit idles high normally, low when infrared encoder selected.
// - Interrupt low in high mode, high in low mode, released in Pc_bus_mode.
// - Pulse width zero gives 3/16 bit; otherwise N clock periods.
// - Divisor bytes reachable only with line control bit 7; form 16 bits.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "urs_regs.svh"
module urs_reg_bank
  import urs_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic [3:0]  MODEM_IN,
  output logic             TX_OUT,
  output logic             INT_OUT,
  output logic             INT_OE_N,
  output logic [2:0]       PC_IRQ_OUT,
  output logic [2:0]       PC_IRQ_OE_N
);
  logic [7:0]  ien_r, fctl_r, istat_r, lctl_r, mctl_r, lstat_r, xtra_r, pw_r, scr_r, enh_r;
  logic [7:0]  res1_r, res2_r, pau1_r, pau2_r, divl_r, divh_r, tx_hold_r, mode_r;
  logic [3:0]  mdm_chg_r, mdm_s1_r, mdm_s2_r, mdm_prev_r;
  logic [1:0]  mdm_warm_r;
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  aw_addr_r;
  logic [7:0]  w_data_r;
  logic        w_lane_r;
  logic        wr_go;
  logic        rd_go;
  logic [7:0]  rd_val;
  logic [1:0]  rd_resp;
  logic [15:0] divisor;
  logic [11:0] baud_cnt_r;
  logic        ir_start_r, ir_pulse;
  logic        dlab;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a[1:0] == 2'b00) && (a <= `URS_OFF_MODE);
  endfunction

  assign dlab    = lctl_r[`URS_LCTL_DLAB_BIT];
  assign divisor = {divh_r, divl_r};

  // Write address and data are taken independently, answered when both held
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= S_AXI_AWADDR;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      w_hold_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_hold_r <= 1'b1;
      w_data_r <= S_AXI_WDATA[7:0];
      w_lane_r <= S_AXI_WSTRB[0];
    end else if (wr_go) begin
      w_hold_r <= 1'b0;
    end
  end

  assign wr_go = aw_hold_r && w_hold_r && !S_AXI_BVALID;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'b00;
    end else begin
      S_AXI_AWREADY <= !aw_hold_r && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID && !wr_go;
      S_AXI_WREADY  <= !w_hold_r && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID && !wr_go;
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= known_addr(aw_addr_r) ? 2'b00 : 2'b10;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Register writes; divisor bytes only with the latch bit set
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ien_r  <= `URS_RST_ZERO;
      fctl_r <= `URS_RST_ZERO;
      lctl_r <= `URS_RST_ZERO;
      mctl_r <= `URS_RST_ZERO;
      xtra_r <= `URS_RST_ZERO;
      pw_r   <= `URS_RST_ZERO;
      enh_r  <= `URS_RST_ZERO;
      scr_r  <= `URS_RST_SCR;
      res1_r <= `URS_RST_ZERO;
      res2_r <= `URS_RST_ZERO;
      pau1_r <= `URS_RST_ZERO;
      pau2_r <= `URS_RST_ZERO;
      mode_r <= `URS_RST_ZERO;
    end else if (wr_go && w_lane_r) begin
      case (aw_addr_r)
        `URS_OFF_IEN:     ien_r  <= w_data_r;
        `URS_OFF_ISTAT:   fctl_r <= w_data_r;
        `URS_OFF_LCTL:    lctl_r <= w_data_r;
        `URS_OFF_MCTL:    mctl_r <= w_data_r;
        `URS_OFF_SCR:     scr_r  <= w_data_r;
        `URS_OFF_XTRA:    xtra_r <= w_data_r;
        `URS_OFF_PW:      pw_r   <= w_data_r;
        `URS_OFF_ENH:     enh_r  <= w_data_r;
        `URS_OFF_RES1:    res1_r <= w_data_r;
        `URS_OFF_RES2:    res2_r <= w_data_r;
        `URS_OFF_PAU1:    pau1_r <= w_data_r;
        `URS_OFF_PAU2:    pau2_r <= w_data_r;
        `URS_OFF_MODE:    mode_r <= w_data_r;
        default: ;
      endcase
    end
  end

  // Divisor and holding bytes have no reset value
  always_ff @(posedge REF_CLK) begin
    if (wr_go && w_lane_r && dlab && aw_addr_r == `URS_OFF_DIVL) begin
      divl_r <= w_data_r;
    end
    if (wr_go && w_lane_r && dlab && aw_addr_r == `URS_OFF_DIVH) begin
      divh_r <= w_data_r;
    end
    if (wr_go && w_lane_r && aw_addr_r == `URS_OFF_DATA) begin
      tx_hold_r <= w_data_r;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      istat_r <= `URS_RST_ISTAT;
      lstat_r <= `URS_RST_LSTAT;
    end else begin
      istat_r <= `URS_RST_ISTAT;
      lstat_r <= `URS_RST_LSTAT;
    end
  end

  // Modem inputs synchronised; change bits set on edges, cleared by status read
  // Edges are ignored until the synchroniser holds real pin levels after reset
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mdm_s1_r   <= 4'h0;
      mdm_s2_r   <= 4'h0;
      mdm_prev_r <= 4'h0;
      mdm_warm_r <= 2'h0;
      mdm_chg_r  <= 4'h0;
    end else begin
      mdm_s1_r   <= MODEM_IN;
      mdm_s2_r   <= mdm_s1_r;
      mdm_prev_r <= mdm_s2_r;
      if (mdm_warm_r != `URS_MDM_WARM) begin
        mdm_warm_r <= mdm_warm_r + 2'h1;
      end
      if (rd_go && S_AXI_ARADDR == `URS_OFF_MSTAT) begin
        mdm_chg_r <= (mdm_warm_r == `URS_MDM_WARM) ? (mdm_s2_r ^ mdm_prev_r) : 4'h0;
      end else begin
        mdm_chg_r <= mdm_chg_r | ((mdm_warm_r == `URS_MDM_WARM) ? (mdm_s2_r ^ mdm_prev_r) : 4'h0);
      end
    end
  end

  assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;

  always_comb begin
    rd_val  = 8'h00;
    rd_resp = 2'b00;
    case (S_AXI_ARADDR)
      `URS_OFF_DATA:    rd_val = tx_hold_r;
      `URS_OFF_IEN:     rd_val = ien_r;
      `URS_OFF_ISTAT:   rd_val = istat_r;
      `URS_OFF_LCTL:    rd_val = lctl_r;
      `URS_OFF_MCTL:    rd_val = mctl_r;
      `URS_OFF_LSTAT:   rd_val = lstat_r;
      `URS_OFF_MSTAT:   rd_val = {mdm_s2_r, mdm_chg_r};
      `URS_OFF_SCR:     rd_val = scr_r;
      `URS_OFF_DIVL:    rd_val = dlab ? divl_r : 8'h00;
      `URS_OFF_DIVH:    rd_val = dlab ? divh_r : 8'h00;
      `URS_OFF_XTRA:    rd_val = xtra_r;
      `URS_OFF_PW:      rd_val = pw_r;
      `URS_OFF_ENH:     rd_val = enh_r;
      `URS_OFF_RES1:    rd_val = res1_r;
      `URS_OFF_RES2:    rd_val = res2_r;
      `URS_OFF_PAU1:    rd_val = pau1_r;
      `URS_OFF_PAU2:    rd_val = pau2_r;
      `URS_OFF_MODE:    rd_val = mode_r;
      default:          rd_resp = 2'b10;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= 2'b00;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !rd_go;
      if (rd_go) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= {24'h000000, rd_val};
        S_AXI_RRESP  <= rd_resp;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Transmit idle: mark tick every 4096 clocks drives the infrared pulse while line control bit 6 is set
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      baud_cnt_r <= 12'h000;
      ir_start_r <= 1'b0;
    end else begin
      ir_start_r <= 1'b0;
      if (baud_cnt_r == 12'h000) begin
        baud_cnt_r <= 12'hfff;
        ir_start_r <= lctl_r[`URS_LCTL_IR_RUN_BIT];
      end else begin
        baud_cnt_r <= baud_cnt_r - 12'h001;
      end
    end
  end

  urs_ir_pulse u_ir (
    .clk        (REF_CLK),
    .rst        (RST),
    .start      (ir_start_r),
    .bit_cycles (divisor),
    .width_n    (pw_r),
    .pulse      (ir_pulse)
  );

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      TX_OUT      <= 1'b1;
      INT_OUT     <= 1'b0;
      INT_OE_N    <= 1'b0;
      PC_IRQ_OUT  <= 3'b000;
      PC_IRQ_OE_N <= 3'b111;
    end else begin
      TX_OUT <= mode_r[`URS_MODE_IR_BIT] ? ir_pulse : 1'b1;
      unique case (urs_bus_mode_type'(mode_r[2:1]))
        URS_BUS_HIGH: begin
          INT_OUT     <= 1'b0;
          INT_OE_N    <= 1'b0;
          PC_IRQ_OE_N <= 3'b111;
        end
        URS_BUS_LOW: begin
          INT_OUT     <= 1'b1;
          INT_OE_N    <= 1'b0;
          PC_IRQ_OE_N <= 3'b111;
        end
        default: begin
          INT_OUT     <= 1'b0;
          INT_OE_N    <= 1'b1;
          PC_IRQ_OE_N <= 3'b111;
        end
      endcase
      PC_IRQ_OUT <= 3'b000;
    end
  end
endmodule // urs_reg_bank

// >>> core/urs_regs.svh
// Register offsets, reset values and field positions of the UART reset-state register bank
`ifndef URS_REGS_SVH
`define URS_REGS_SVH
`define URS_OFF_DATA      8'h00
`define URS_OFF_IEN       8'h04
`define URS_OFF_ISTAT     8'h08
`define URS_OFF_LCTL      8'h0c
`define URS_OFF_MCTL      8'h10
`define URS_OFF_LSTAT     8'h14
`define URS_OFF_MSTAT     8'h18
`define URS_OFF_SCR       8'h1c
`define URS_OFF_DIVL      8'h20
`define URS_OFF_DIVH      8'h24
`define URS_OFF_XTRA      8'h28
`define URS_OFF_PW        8'h2c
`define URS_OFF_ENH       8'h30
`define URS_OFF_RES1      8'h34
`define URS_OFF_RES2      8'h38
`define URS_OFF_PAU1      8'h3c
`define URS_OFF_PAU2      8'h40
`define URS_OFF_MODE      8'h44
`define URS_RST_ZERO      8'h00
`define URS_RST_ISTAT     8'h01
`define URS_RST_LSTAT     8'h60
`define URS_RST_SCR       8'hff
`define URS_LCTL_DLAB_BIT 7
`define URS_LCTL_IR_RUN_BIT 6
`define URS_IR_OVERSAMPLE 16
`define URS_MDM_WARM      2'h3
`define URS_MODE_IR_BIT   0
`define URS_IR_FRAC_NUM   3
`define URS_IR_FRAC_DEN   16
`endif

// >>> core/urs_pkg.sv
// Types shared by the UART reset-state register bank
package urs_pkg;
  typedef enum logic [1:0] {URS_BUS_HIGH, URS_BUS_LOW, URS_BUS_PC} urs_bus_mode_type;
  typedef enum logic [1:0] {URS_IR_IDLE, URS_IR_PULSE, URS_IR_WAIT} urs_ir_state_type;
endpackage

// >>> core/urs_ir_pulse.sv
// Infrared encoder pulse generator: fixed 3/16 bit or N clock periods
`timescale 1ns/1ps
`include "urs_regs.svh"
module urs_ir_pulse
  import urs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] bit_cycles,
  input  wire logic [7:0]  width_n,
  output logic             pulse
);
  urs_ir_state_type state_r;
  logic [19:0]      cnt_r;
  logic [19:0]      len;
  logic [23:0]      period;

  // bit_cycles carries the baud divisor; one bit lasts sixteen divisor counts
  assign period = {8'h00, bit_cycles} * 24'(`URS_IR_OVERSAMPLE);

  always_comb begin
    if (width_n == 8'h00) begin
      len = 20'((period * 24'(`URS_IR_FRAC_NUM)) / 24'(`URS_IR_FRAC_DEN));
    end else begin
      len = {12'h000, width_n};
    end
    if (len == 20'h00000) begin
      len = 20'h00001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= URS_IR_IDLE;
      cnt_r   <= 20'h00000;
      pulse   <= 1'b0;
    end else begin
      unique case (state_r)
        URS_IR_IDLE: begin
          if (start) begin
            state_r <= URS_IR_PULSE;
            cnt_r   <= len - 20'h00001;
            pulse   <= 1'b1;
          end
        end
        URS_IR_PULSE: begin
          if (cnt_r == 20'h00000) begin
            pulse   <= 1'b0;
            state_r <= URS_IR_WAIT;
          end else begin
            cnt_r <= cnt_r - 20'h00001;
          end
        end
        URS_IR_WAIT: begin
          if (!start) begin
            state_r <= URS_IR_IDLE;
          end
        end
      endcase
    end
  end
endmodule // urs_ir_pulse

// >>> verification/urs_reg_bank_props.sv
// Bus handshake and reset-level assertions for the register bank
`timescale 1ns/1ps
module urs_reg_bank_props (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        TX_OUT,
  input wire logic        INT_OUT,
  input wire logic        INT_OE_N,
  input wire logic [2:0]  PC_IRQ_OE_N
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_pc_release; PC_IRQ_OE_N == 3'b111; endproperty
  a_pc_release: assert property (p_pc_release) else $error("PC irq lines driven");
  // Checked while reset is held, so no disable here
  property p_reset_pins; disable iff (1'b0) RST ##1 RST |-> TX_OUT && !INT_OUT && !INT_OE_N; endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("Pin level wrong in reset");
  property p_rdata_upper; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000; endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("Read data upper bits set");
  property p_rd_answer; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("Read answer late");
  property p_wr_answer;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("Write answer late");
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("Write response dropped");
  property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("Read data dropped");
  property p_busy; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
  a_busy: assert property (p_busy) else $error("Ready high while busy");
endmodule // urs_reg_bank_props
bind urs_reg_bank urs_reg_bank_props i_urs_reg_bank_props (.*);

// >>> verification/urs_line_partner.sv
// Far-side line model: modem input levels and idle receive line
`timescale 1ns/1ps
module urs_line_partner (
  input wire logic [3:0] set_lvl,
  output logic [3:0]     modem_out,
  output logic           rx_idle
);
  assign modem_out = set_lvl;
  assign rx_idle   = 1'b1;
endmodule // urs_line_partner

// >>> verification/uart_reset_state_logic_bench.sv
// Register-level testbench for the UART reset-state register bank
`timescale 1ns/1ps
module uart_reset_state_logic_bench;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic [3:0]  lvl = 4'ha;
  logic [1:0]  resp;
  wire  [31:0] rdata;
  wire  [3:0]  modem;
  wire  [2:0]  pc_oe_n;
  wire  [1:0]  bresp, rresp;
  wire         awrdy, wrdy, bvalid, arrdy, rvalid, tx, int_o, int_oe_n;
  int          fails = 0, checks_done = 0, cyc = 0, i, n, w;
  always #4 clk = ~clk;
  urs_reg_bank i_urs_reg_bank (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .MODEM_IN(modem), .TX_OUT(tx), .INT_OUT(int_o),
    .INT_OE_N(int_oe_n), .PC_IRQ_OUT(), .PC_IRQ_OE_N(pc_oe_n));
  urs_line_partner i_urs_line_partner (.set_lvl(lvl), .modem_out(modem), .rx_idle());
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus access; valids drop as each channel is taken, waits for the answer
  task automatic acc(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    if (wr) begin
      awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
    end else begin
      araddr <= a; arv <= 1; rready <= 1;
    end
    forever begin
      @(posedge clk);
      if (awv && awrdy) awv <= 0;
      if (wv && wrdy) wv <= 0;
      if (arv && arrdy) arv <= 0;
      if (bready && bvalid) begin
        resp = bresp; bready <= 0; break;
      end
      if (rready && rvalid) begin
        resp = rresp; rd = rdata; rready <= 0; break;
      end
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("Error cycle limit expected %0d seen %0d", 20000, cyc);
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (4) @(posedge clk);
    chk("tx idle", 32'h1, tx);
    chk("int level", 32'h0, int_o);
    for (i = 1; i < 18; i++) if (i != 6 && i != 8 && i != 9) begin
      acc(0, 8'(4 * i), 0);
      chk("reset value", (i == 2) ? 32'h1 : (i == 5) ? 32'h60 : (i == 7) ? 32'hff : 32'h0, rd);
    end
    acc(0, 8'h18, 0);
    chk("modem status", 32'ha0, rd);
    lvl <= 4'h5;
    repeat (6) @(posedge clk);
    acc(0, 8'h18, 0);
    chk("modem change", 32'h5f, rd);
    for (i = 0; i < 4; i++) acc(1, 8'(8'h34 + 4 * i), 32'hab000011 * (i + 1));
    for (i = 0; i < 4; i++) begin
      acc(0, 8'(8'h34 + 4 * i), 0);
      chk("flow char", 32'h11 * (i + 1), rd);
    end
    acc(1, 8'h20, 32'h55);
    acc(0, 8'h20, 0);
    chk("divisor locked", 32'h0, rd);
    acc(1, 8'h0c, 32'h80);
    acc(1, 8'h20, 32'h20);
    acc(1, 8'h24, 32'h0);
    acc(0, 8'h20, 0);
    chk("divisor low", 32'h20, rd);
    acc(0, 8'h48, 0);
    chk("unmapped resp", 32'h2, resp);
    acc(1, 8'h05, 32'h1);
    chk("misaligned resp", 32'h2, resp);
    acc(1, 8'h44, 32'h2);
    repeat (3) @(posedge clk);
    chk("int low mode", 32'h1, int_o);
    acc(1, 8'h44, 32'h4);
    repeat (3) @(posedge clk);
    chk("pc release", 32'h7, pc_oe_n);
    chk("int release", 32'h1, int_oe_n);
    acc(1, 8'h44, 32'h1);
    repeat (3) @(posedge clk);
    chk("tx infrared", 32'h0, tx);
    acc(1, 8'h30, 32'h10);
    acc(1, 8'h0c, 32'hc0);
    for (i = 0; i < 2; i++) begin
      acc(1, 8'h2c, i ? 32'h0 : 32'h5);
      while (tx === 1'b1) @(posedge clk);
      for (n = 0; n < 5000 && tx !== 1'b1; n++) @(posedge clk);
      for (w = 0; w < 300 && tx === 1'b1; w++) @(posedge clk);
      chk("pulse width", i ? 32'h60 : 32'h5, w);
    end
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (4) @(posedge clk);
    chk("tx after reset", 32'h1, tx);
    acc(0, 8'h40, 0);
    chk("pause char reset", 32'h0, rd);
    acc(0, 8'h18, 0);
    chk("modem after reset", 32'h50, rd);
    test_done();
  end
endmodule // uart_reset_state_logic_bench
